/* hdl/umc_core.sv */
// Our own choices: the placing of the registers and the AHB-Lite register port.
`timescale 1ns/1ps
`default_nettype none
module umc_core (
   // clock and reset
   input  wire logic                        hclk,
   input  wire logic                        hresetn,
   // ahb-lite slave
   input  wire logic                        hsel,
   input  wire logic [31:0]                 haddr,
   input  wire logic [1:0]                  htrans,
   input  wire logic                        hwrite,
   input  wire logic [2:0]                  hsize,
   input  wire logic [31:0]                 hwdata,
   input  wire logic                        hready,
   output logic      [31:0]                 hrdata,
   output logic                             hreadyout,
   output logic                             hresp,
   // downstream timebase
   input  wire logic                        ts_valid,
   input  wire logic [31:0]                 ts_value,
   input  wire logic                        sync_lost,
   // ranging responses from head-end
   input  wire logic                        rsp_valid,
   input  wire logic                        rsp_success,
   input  wire logic                        rsp_abort,
   input  wire logic                        bcast_done,
   // MAP element stream
   input  wire logic                        map_start,
   input  wire logic                        elem_valid,
   input  wire umc_pkg::umc_elem_t          elem_kind,
   input  wire logic [umc_pkg::UMC_SID_W-1:0] elem_sid,
   input  wire logic [umc_pkg::UMC_IUC_W-1:0] elem_iuc,
   input  wire logic [umc_pkg::UMC_LEN_W-1:0] elem_len,
   input  wire logic                        elem_unicast,
   input  wire logic                        elem_grant,
   input  wire logic                        elem_ack,
   input  wire logic                        map_end,
   input  wire logic                        map_ack_late,
   // pending data PDU
   input  wire logic                        pdu_pending,
   // transmit side
   output logic                             tx_go,
   output logic                             tx_ranging,
   output logic [umc_pkg::UMC_SID_W-1:0]    tx_sid,
   output logic [umc_pkg::UMC_BURST_W-1:0]  tx_burst,
   output logic                             pdu_discard,
   output logic                             pdu_done,
   output logic [31:0]                      mslot_cnt
);

   // ---------------------------------------------------------------------
   // bus slave
   // ---------------------------------------------------------------------
   logic                                   ph_q;
   logic                                   ph_wr_q;
   logic [11:0]                            ph_addr_q;
   logic                                   ctl_start_q;
   logic                                   ctl_retain_q;
   logic                                   ctl_abort_q;
   logic [umc_pkg::UMC_SID_W-1:0]          sid_q;
   logic [umc_pkg::UMC_EXP_W-1:0]          dstart_q;
   logic [umc_pkg::UMC_EXP_W-1:0]          dend_q;
   logic [umc_pkg::UMC_EXP_W-1:0]          rstart_q;
   logic [umc_pkg::UMC_EXP_W-1:0]          rend_q;
   logic [umc_pkg::UMC_EXP_W-1:0]          m_q;
   logic [umc_pkg::UMC_LEN_W-1:0]          reqsz_q;
   logic [umc_pkg::UMC_BURST_W-1:0]        burst_map_q [umc_pkg::UMC_NIUC];
   logic [3:0]                             burst_idx_q;
   logic [7:0]                             events_q;
   umc_pkg::umc_state_t                    state_q;
   logic [4:0]                             retry_q;
   logic [umc_pkg::UMC_CNT_W-1:0]          defer_q;
   logic [umc_pkg::UMC_EXP_W-1:0]          win_q;
   logic                                   rng_q;
   logic [15:0]                            lfsr_q;

   wire logic take = hsel && hready && htrans[1];
   wire logic wr_go = ph_q && ph_wr_q;

   assign hreadyout = 1'b1;
   assign hresp     = 1'b0;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ph_q      <= 1'b0;
         ph_wr_q   <= 1'b0;
         ph_addr_q <= 12'h000;
      end else begin
         ph_q      <= take;
         ph_wr_q   <= hwrite;
         ph_addr_q <= haddr[11:0];
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ctl_start_q  <= 1'b0;
         ctl_retain_q <= 1'b0;
         ctl_abort_q  <= 1'b0;
         sid_q        <= '0;
         dstart_q     <= '0;
         dend_q       <= '0;
         rstart_q     <= '0;
         rend_q       <= '0;
         m_q          <= '0;
         reqsz_q      <= 8'h01;
         burst_idx_q  <= 4'h0;
      end else begin
         ctl_start_q <= 1'b0;
         ctl_abort_q <= 1'b0;
         if (wr_go) begin
            if (ph_addr_q == umc_pkg::UMC_CTRL_OFS) begin
               ctl_start_q  <= hwdata[0];
               ctl_retain_q <= hwdata[1];
               ctl_abort_q  <= hwdata[2];
            end else if (ph_addr_q == umc_pkg::UMC_SID_OFS) begin
               sid_q <= hwdata[umc_pkg::UMC_SID_W-1:0];
            end else if (ph_addr_q == umc_pkg::UMC_DBKO_OFS) begin
               dstart_q <= hwdata[umc_pkg::UMC_EXP_W-1:0];
               dend_q   <= hwdata[umc_pkg::UMC_BKO_END +: umc_pkg::UMC_EXP_W];
            end else if (ph_addr_q == umc_pkg::UMC_RBKO_OFS) begin
               rstart_q <= hwdata[umc_pkg::UMC_EXP_W-1:0];
               rend_q   <= hwdata[umc_pkg::UMC_BKO_END +: umc_pkg::UMC_EXP_W];
            end else if (ph_addr_q == umc_pkg::UMC_SLOT_OFS) begin
               m_q     <= hwdata[umc_pkg::UMC_M_LSB +: umc_pkg::UMC_EXP_W];
               reqsz_q <= hwdata[umc_pkg::UMC_REQSZ_LSB +: umc_pkg::UMC_LEN_W];
            end else if (ph_addr_q == umc_pkg::UMC_BURST_OFS) begin
               burst_idx_q <= hwdata[11:8];
            end
         end
      end
   end

   // burst table: write selects entry hwdata[11:8], data in [3:0]
   genvar gi;
   generate
      for (gi = 0; gi < umc_pkg::UMC_NIUC; gi++) begin : g_burst
         always_ff @(posedge hclk or negedge hresetn) begin
            if (!hresetn) begin
               burst_map_q[gi] <= '0;
            end else if (wr_go && ph_addr_q == umc_pkg::UMC_BURST_OFS &&
                         hwdata[11:8] == 4'(gi)) begin
               burst_map_q[gi] <= hwdata[umc_pkg::UMC_BURST_W-1:0];
            end
         end
      end
   endgenerate

   always_comb begin
      hrdata = 32'h0000_0000;
      if (ph_addr_q == umc_pkg::UMC_CTRL_OFS) begin
         hrdata = {30'h0, ctl_retain_q, 1'b0};
      end else if (ph_addr_q == umc_pkg::UMC_SID_OFS) begin
         hrdata = {18'h0, sid_q};
      end else if (ph_addr_q == umc_pkg::UMC_DBKO_OFS) begin
         hrdata = {20'h0, dend_q, 4'h0, dstart_q};
      end else if (ph_addr_q == umc_pkg::UMC_RBKO_OFS) begin
         hrdata = {20'h0, rend_q, 4'h0, rstart_q};
      end else if (ph_addr_q == umc_pkg::UMC_SLOT_OFS) begin
         hrdata = {16'h0, reqsz_q, 4'h0, m_q};
      end else if (ph_addr_q == umc_pkg::UMC_STATUS_OFS) begin
         hrdata = {3'h0, retry_q, win_q, defer_q[7:0], 5'h0, state_q,
                   3'h0, rng_q};
      end else if (ph_addr_q == umc_pkg::UMC_MSLOT_OFS) begin
         hrdata = mslot_cnt;
      end else if (ph_addr_q == umc_pkg::UMC_BURST_OFS) begin
         hrdata = {20'h0, burst_idx_q, 4'h0, burst_map_q[burst_idx_q]};
      end else if (ph_addr_q == umc_pkg::UMC_EVENT_OFS) begin
         hrdata = {24'h0, events_q};
      end
   end

   // ---------------------------------------------------------------------
   // mini-slot counter
   // ---------------------------------------------------------------------
   wire logic [5:0] sh = 6'(umc_pkg::UMC_TS_SHIFT) + {2'b00, m_q};

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         mslot_cnt <= 32'h0000_0000;
      end else if (sync_lost) begin
         mslot_cnt <= 32'h0000_0000;
      end else if (ts_valid) begin
         // upper bits unused and left zero
         mslot_cnt <= ts_value >> sh;
      end
   end

   // ---------------------------------------------------------------------
   // pseudo-random source
   // ---------------------------------------------------------------------
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         lfsr_q <= umc_pkg::UMC_LFSR_SEED;
      end else begin
         lfsr_q <= lfsr_q[0] ? ((lfsr_q >> 1) ^ umc_pkg::UMC_LFSR_TAPS)
                             : (lfsr_q >> 1);
      end
   end

   function automatic logic [15:0] draw(input logic [3:0] e,
                                        input logic [15:0] r);
      logic [15:0] mask;
      mask = 16'(({1'b0, 16'hFFFF} >> (5'h10 - {1'b0, e})));
      draw = r & mask; // window 0..2^e-1
   endfunction

   // ---------------------------------------------------------------------
   // contention and ranging engine
   // ---------------------------------------------------------------------
   wire logic [umc_pkg::UMC_LEN_W-1:0] ops_reqsz =
      (reqsz_q == '0) ? 8'h01 : reqsz_q;
   logic [umc_pkg::UMC_CNT_W-1:0] ops;
   always_comb begin
      ops = '0;
      if (elem_kind == umc_pkg::UMC_ELEM_IMAIN) begin
         ops = 16'h0001;
      end else if (elem_kind == umc_pkg::UMC_ELEM_REQ ||
                   elem_kind == umc_pkg::UMC_ELEM_REQD) begin
         ops = {8'h00, elem_len / ops_reqsz};
      end
   end

   wire logic mine      = elem_valid && elem_sid == sid_q;
   wire logic eligible  = elem_valid && !elem_unicast && (rng_q ?
      elem_kind == umc_pkg::UMC_ELEM_IMAIN :
      (elem_kind == umc_pkg::UMC_ELEM_REQ ||
       elem_kind == umc_pkg::UMC_ELEM_REQD));
   wire logic [umc_pkg::UMC_EXP_W-1:0] w_end = rng_q ? rend_q : dend_q;
   wire logic fire_ctn  = state_q == umc_pkg::UMC_DEFER && eligible &&
                          defer_q < ops;
   wire logic fire_uni  = state_q == umc_pkg::UMC_DEFER && mine &&
                          elem_unicast && !rng_q;
   wire logic fire_rng  = state_q == umc_pkg::UMC_RNG_WAIT && mine &&
                          elem_unicast && (elem_kind ==
                          umc_pkg::UMC_ELEM_IMAIN || elem_grant);
   wire logic fire_data = state_q == umc_pkg::UMC_ONLINE && mine &&
                          elem_grant;
   wire logic got_ack   = state_q == umc_pkg::UMC_ACK_WAIT && mine &&
                          (elem_grant || elem_ack);
   wire logic lost      = state_q == umc_pkg::UMC_ACK_WAIT && map_end &&
                          map_ack_late;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         state_q <= umc_pkg::UMC_IDLE;
         retry_q <= 5'h00;
         defer_q <= '0;
         win_q   <= '0;
         rng_q   <= 1'b0;
      end else if (sync_lost || ctl_abort_q) begin
         state_q <= umc_pkg::UMC_IDLE;
         rng_q   <= 1'b0;
      end else begin
         case (state_q)
            umc_pkg::UMC_IDLE: begin
               if (ctl_start_q || bcast_done) begin
                  state_q <= umc_pkg::UMC_RNG_WAIT;
               end
            end
            umc_pkg::UMC_RNG_WAIT: begin
               if (fire_rng) begin
                  state_q <= umc_pkg::UMC_RNG_RSP;
               end
            end
            umc_pkg::UMC_RNG_RSP: begin
               if (rsp_valid && rsp_abort) begin
                  state_q <= umc_pkg::UMC_IDLE;
               end else if (rsp_valid && rsp_success) begin
                  state_q <= umc_pkg::UMC_ONLINE;
               end else if (rsp_valid) begin
                  state_q <= umc_pkg::UMC_RNG_WAIT;
               end
            end
            umc_pkg::UMC_ONLINE: begin
               if (pdu_pending && !fire_data) begin
                  state_q <= umc_pkg::UMC_DEFER;
                  retry_q <= 5'h00;
                  win_q   <= dstart_q;
                  defer_q <= draw(dstart_q, lfsr_q);
               end
            end
            umc_pkg::UMC_DEFER: begin
               if (fire_uni) begin
                  state_q <= umc_pkg::UMC_ONLINE;
               end else if (fire_ctn) begin
                  state_q <= umc_pkg::UMC_ACK_WAIT;
               end else if (eligible) begin
                  defer_q <= defer_q - ops;
               end
            end
            umc_pkg::UMC_ACK_WAIT: begin
               if (got_ack) begin
                  state_q <= umc_pkg::UMC_ONLINE;
               end else if (lost) begin
                  if (retry_q + 5'h01 >= umc_pkg::UMC_MAX_RETRY) begin
                     state_q <= umc_pkg::UMC_ONLINE;
                  end else begin
                     state_q <= umc_pkg::UMC_DEFER;
                     retry_q <= retry_q + 5'h01;
                     win_q   <= (win_q < w_end) ? win_q + 4'h1 : win_q;
                     defer_q <= draw((win_q < w_end) ? win_q + 4'h1 : win_q,
                                     lfsr_q);
                  end
               end
            end
            default: begin
               state_q <= umc_pkg::UMC_IDLE;
            end
         endcase
      end
   end

   // outputs of the transmit side
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         tx_go       <= 1'b0;
         tx_ranging  <= 1'b0;
         tx_sid      <= '0;
         tx_burst    <= '0;
         pdu_discard <= 1'b0;
         pdu_done    <= 1'b0;
         events_q    <= 8'h00;
      end else begin
         tx_go       <= fire_rng || fire_ctn || fire_uni || fire_data;
         tx_ranging  <= fire_rng;
         tx_sid      <= sid_q; // temp or retained sid
         tx_burst    <= burst_map_q[elem_iuc];
         pdu_discard <= lost && retry_q + 5'h01 >= umc_pkg::UMC_MAX_RETRY;
         pdu_done    <= got_ack || fire_uni || fire_data;
         if (fire_rng)   events_q[0] <= 1'b1;
         if (lost)       events_q[1] <= 1'b1;
         if (state_q == umc_pkg::UMC_ONLINE) events_q[2] <= 1'b1;
      end
   end

   // ---------------------------------------------------------------------
   // checks
   // ---------------------------------------------------------------------
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);

   mslot_track_a: assert property (ts_valid && !sync_lost |=>
      mslot_cnt == ($past(ts_value) >> ($past(sh))))
      else $error("mini-slot count off timestamp");
   rng_succ_a: assert property (state_q == umc_pkg::UMC_RNG_RSP &&
      rsp_valid && rsp_success && !rsp_abort && !sync_lost && !ctl_abort_q
      |=> state_q == umc_pkg::UMC_ONLINE)
      else $error("ranging success ignored");
   rng_abort_a: assert property (state_q == umc_pkg::UMC_RNG_RSP &&
      rsp_valid && rsp_abort |=> state_q == umc_pkg::UMC_IDLE)
      else $error("abort ignored");
   rng_tx_a: assert property (fire_rng |=> tx_go && tx_ranging &&
      tx_sid == $past(sid_q))
      else $error("ranging request not sent");
   win_cap_a: assert property (state_q == umc_pkg::UMC_DEFER &&
      $past(state_q) == umc_pkg::UMC_ACK_WAIT |->
      ($past(win_q) < $past(w_end) && win_q == $past(win_q) + 4'h1) ||
      ($past(win_q) >= $past(w_end) && win_q == $past(win_q)))
      else $error("window step wrong after loss");
   retry_lim_a: assert property (retry_q < umc_pkg::UMC_MAX_RETRY)
      else $error("retry count past limit");
   draw_rng_a: assert property (
      $rose(state_q == umc_pkg::UMC_DEFER) &&
      $past(state_q) == umc_pkg::UMC_ONLINE |->
      defer_q < (17'h1 << win_q))
      else $error("deferral outside window");
   uni_win_a: assert property (fire_uni && !sync_lost && !ctl_abort_q
      |=> state_q == umc_pkg::UMC_ONLINE ##0 pdu_done)
      else $error("unicast opportunity not taken");
   lost_a: assert property (lost && !got_ack && !sync_lost &&
      !ctl_abort_q && retry_q < 5'h0F |=> state_q == umc_pkg::UMC_DEFER)
      else $error("loss not retried");
   imain_a: assert property (elem_kind == umc_pkg::UMC_ELEM_IMAIN |->
      ops == 16'h0001)
      else $error("maintenance element count");

   rng_cov_c:  cover property (state_q == umc_pkg::UMC_RNG_RSP ##1
                               state_q == umc_pkg::UMC_ONLINE);
   defer_cov_c: cover property (fire_ctn);
   lost_cov_c: cover property (lost);
   disc_cov_c: cover property (pdu_discard);

endmodule
`default_nettype wire

/* hdl/umc_pkg.sv */
package umc_pkg;

   // ---------------------------------------------------------------------
   // register map
   // ---------------------------------------------------------------------
   localparam logic [11:0] UMC_CTRL_OFS    = 12'h000;
   localparam logic [11:0] UMC_SID_OFS     = 12'h004;
   localparam logic [11:0] UMC_DBKO_OFS    = 12'h008;
   localparam logic [11:0] UMC_RBKO_OFS    = 12'h00C;
   localparam logic [11:0] UMC_SLOT_OFS    = 12'h010;
   localparam logic [11:0] UMC_STATUS_OFS  = 12'h014;
   localparam logic [11:0] UMC_MSLOT_OFS   = 12'h018;
   localparam logic [11:0] UMC_BURST_OFS   = 12'h01C;
   localparam logic [11:0] UMC_EVENT_OFS   = 12'h020;

   // ---------------------------------------------------------------------
   // field layout
   // ---------------------------------------------------------------------
   localparam int UMC_M_LSB      = 0;   // slot register: mini-slot exponent
   localparam int UMC_REQSZ_LSB  = 8;   // slot register: slots per request
   localparam int UMC_BKO_END    = 8;   // backoff regs: end exponent lsb
   localparam int UMC_EXP_W      = 4;
   localparam int UMC_SID_W      = 14;
   localparam int UMC_IUC_W      = 4;
   localparam int UMC_BURST_W    = 4;
   localparam int UMC_LEN_W      = 8;
   localparam int UMC_CNT_W      = 16;
   localparam int UMC_NIUC       = 16;

   localparam logic [4:0]  UMC_MAX_RETRY = 5'h10;
   localparam int          UMC_TS_SHIFT  = 6;
   localparam logic [15:0] UMC_LFSR_SEED = 16'hACE1;
   localparam logic [15:0] UMC_LFSR_TAPS = 16'hB400;

   // ---------------------------------------------------------------------
   // types
   // ---------------------------------------------------------------------
   typedef enum logic [2:0] {
      UMC_IDLE     = 3'b000,
      UMC_RNG_WAIT = 3'b001,
      UMC_RNG_RSP  = 3'b010,
      UMC_DEFER    = 3'b011,
      UMC_ACK_WAIT = 3'b100,
      UMC_ONLINE   = 3'b101
   } umc_state_t;

   typedef enum logic [1:0] {
      UMC_ELEM_REQ   = 2'b00,
      UMC_ELEM_REQD  = 2'b01,
      UMC_ELEM_IMAIN = 2'b10,
      UMC_ELEM_OTHER = 2'b11
   } umc_elem_t;

endpackage

/* test/umc_headend.sv */
`timescale 1ns/1ps
`default_nettype none
module umc_headend #(parameter int NFAIL = 2) (
   // clock and reset
   input  wire logic hclk,
   input  wire logic hresetn,
   // upstream from the modem
   input  wire logic tx_go,
   input  wire logic tx_ranging,
   // ranging responses
   output logic      rsp_valid,
   output logic      rsp_success,
   output logic      rsp_abort
);
   // ----------------------------------------------------------------
   // answer each ranging request a few cycles later
   // ----------------------------------------------------------------
   int cnt;
   int dly;
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         cnt <= 0;
         dly <= 0;
         rsp_valid <= 1'b0;
         rsp_success <= 1'b0;
         rsp_abort <= 1'b0;
      end else begin
         rsp_valid <= (dly == 1);
         // qualifiers wander while no response stands
         rsp_success <= (dly == 1) ? (cnt > NFAIL) : ~rsp_success;
         rsp_abort <= (dly == 1) ? 1'b0 : ~rsp_abort;
         if (tx_go && tx_ranging) begin
            dly <= 3;
            cnt <= cnt + 1;
         end else if (dly != 0) begin
            dly <= dly - 1;
         end
      end
   end
endmodule
`default_nettype wire

/* test/upstream_minislot_contention_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module upstream_minislot_contention_tb_top;
   logic               hclk = 0, hresetn = 0, hsel = 0, hwrite = 0;
   logic        [31:0] haddr = '0, hwdata = '0, ts_value = '0, hrdata;
   logic        [31:0] mslot_cnt, rd, seed = 32'h404D1396;
   logic         [1:0] htrans = '0;
   logic         [2:0] hsize = 3'h2;
   logic               ts_valid = 0, sync_lost = 0, bcast_done = 0;
   logic               map_start = 0, elem_valid = 0, elem_unicast = 0;
   logic               elem_grant = 0, elem_ack = 0, map_end = 0;
   logic               map_ack_late = 0, pdu_pending = 0;
   umc_pkg::umc_elem_t elem_kind = umc_pkg::UMC_ELEM_OTHER;
   logic        [13:0] elem_sid = '0, tx_sid;
   logic         [3:0] elem_iuc = '0, tx_burst, o, btab [16];
   logic         [7:0] elem_len = 8'h01;
   logic               hreadyout, hresp, tx_go, tx_ranging, pdu_discard;
   logic               pdu_done, rsp_valid, rsp_success, rsp_abort;
   int                 fails = 0, checks = 0, i, m;

   always #12.5 hclk = ~hclk;

   umc_core dut_u (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
      .hsize, .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp,
      .ts_valid, .ts_value, .sync_lost, .rsp_valid, .rsp_success,
      .rsp_abort, .bcast_done, .map_start, .elem_valid, .elem_kind,
      .elem_sid, .elem_iuc, .elem_len, .elem_unicast, .elem_grant,
      .elem_ack, .map_end, .map_ack_late, .pdu_pending, .tx_go,
      .tx_ranging, .tx_sid, .tx_burst, .pdu_discard, .pdu_done,
      .mslot_cnt);
   umc_headend #(.NFAIL(2)) he_u (.hclk, .hresetn, .tx_go, .tx_ranging,
      .rsp_valid, .rsp_success, .rsp_abort);

   // ----------------------------------------------------------------
   // shared tasks
   // ----------------------------------------------------------------
   function automatic logic [31:0] xs();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction
   task automatic chk(input string n, input logic [31:0] e, s);
      checks++;
      if (s !== e) begin
         fails++;
         $display("MISMATCH %s exp %h got %h", n, e, s);
      end
   endtask
   task automatic bus(input logic w, input logic [11:0] a, d);
      hsel <= 1; htrans <= 2'h2; hwrite <= w; haddr <= {20'h0, a};
      do @(posedge hclk); while (hreadyout !== 1'b1);
      hsel <= 0; htrans <= 2'h0; hwdata <= {20'h0, d};
      do @(posedge hclk); while (hreadyout !== 1'b1);
      rd = hrdata;
      chk("hresp", 0, hresp);
   endtask
   // v low sends a map end whose ack time passed our transmission
   task automatic el(input umc_pkg::umc_elem_t k, input logic [13:0] s,
         input logic [2:0] uga, input logic [3:0] iuc, input logic v);
      elem_valid <= v; map_end <= ~v; map_ack_late <= ~v; elem_kind <= k;
      elem_sid <= s; {elem_unicast, elem_grant, elem_ack} <= uga;
      elem_iuc <= iuc;
      @(posedge hclk);
      elem_valid <= 0; map_end <= 0; map_ack_late <= 0; elem_sid <= ~s;
      #1 o = {tx_go, tx_ranging, pdu_done, pdu_discard};
      @(posedge hclk);
   endtask
   task automatic finish_test();
      if (fails == 0 && checks > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask

   initial begin
      #(25ns * 6000);
      fails++;
      finish_test();
   end

   // ----------------------------------------------------------------
   // scenarios
   // ----------------------------------------------------------------
   initial begin
      repeat (12) @(posedge hclk);
      hresetn <= 1;
      @(posedge hclk);
      bus(0, 12'h0FC, 0);
      chk("unmapped", 0, rd);
      for (m = 0; m < 6; m += 2) begin
         bus(1, umc_pkg::UMC_SLOT_OFS, 12'h100 | 12'(m));
         ts_value <= xs(); ts_valid <= 1;
         @(posedge hclk);
         ts_valid <= 0;
         #1 chk("mslot", ts_value >> (6 + m), mslot_cnt);
         @(posedge hclk);
      end
      sync_lost <= 1;
      @(posedge hclk);
      sync_lost <= 0;
      #1 chk("lost", 0, mslot_cnt);
      @(posedge hclk);
      for (i = 0; i < 16; i++) begin
         rd = xs(); btab[i] = rd[3:0];
         bus(1, umc_pkg::UMC_BURST_OFS, {i[3:0], 4'h0, btab[i]});
      end
      for (i = 0; i < 16; i++) begin
         el(umc_pkg::UMC_ELEM_OTHER, 0, 0, i[3:0], 1);
         chk("burst", btab[i], tx_burst);
      end
      bus(1, umc_pkg::UMC_SID_OFS, 12'h123);
      bus(1, umc_pkg::UMC_CTRL_OFS, 1);
      bcast_done <= 1;
      @(posedge hclk);
      bcast_done <= 0;
      el(umc_pkg::UMC_ELEM_IMAIN, 14'h456, 3'h4, 0, 1);
      chk("other sid", 0, o);
      for (i = 0; i < 3; i++) begin
         el(umc_pkg::UMC_ELEM_IMAIN, 14'h123, 3'h4, 0, 1);
         chk("rng", 4'hC, o);
         chk("sid", 14'h123, tx_sid);
         repeat (6) @(posedge hclk);
      end
      bus(0, umc_pkg::UMC_STATUS_OFS, 0);
      chk("online", umc_pkg::UMC_ONLINE, rd[6:4]);
      bus(1, umc_pkg::UMC_DBKO_OFS, 0);
      pdu_pending <= 1;
      @(posedge hclk);
      for (i = 0; i < 16; i++) begin
         el(umc_pkg::UMC_ELEM_REQ, 0, 0, 0, 1);
         chk("ctx", 4'h8, o);
         el(umc_pkg::UMC_ELEM_OTHER, 0, 0, 0, 0);
         chk("loss", i == 15, o[0]);
      end
      pdu_pending <= 0;
      for (m = 0; m < 2; m++) begin
         bus(1, umc_pkg::UMC_DBKO_OFS, m ? 12'hA0A : 0);
         pdu_pending <= 1;
         @(posedge hclk);
         pdu_pending <= 0;
         el(umc_pkg::UMC_ELEM_REQ, m ? 14'h123 : 0, m ? 3'h4 : 0, 0, 1);
         chk("tx", m ? 4'hA : 4'h8, o);
         el(umc_pkg::UMC_ELEM_OTHER, 14'h123, m ? 3'h2 : 3'h1, 0, 1);
         chk("done", m ? 4'hA : 4'h2, o);
      end
      finish_test();
   end
endmodule
`default_nettype wire
